// >>> timer_pair_pkg.sv
// Purpose: Shared constants for the dual timer/counter pair.
// Assumes: Registers are reached over the core's special function bus.
// Notes: Addresses are the special function register addresses.
package timer_pair_pkg;

    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [7:0] ADDR_TIMER_CONTROL_FLAGS = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE_CONFIG = 8'h89;
    localparam logic [7:0] ADDR_COUNTER_A_LOW_BYTE = 8'h8a;
    localparam logic [7:0] ADDR_COUNTER_B_LOW_BYTE = 8'h8b;
    localparam logic [7:0] ADDR_COUNTER_A_HIGH_BYTE = 8'h8c;
    localparam logic [7:0] ADDR_COUNTER_B_HIGH_BYTE = 8'h8d;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ************************************************************
    // Control register bit positions
    // ************************************************************
    localparam int OVF_B_BIT = 7;
    localparam int RUN_B_BIT = 6;
    localparam int OVF_A_BIT = 5;
    localparam int RUN_A_BIT = 4;
    localparam int IRQ_B_FLAG_BIT = 3;
    localparam int IRQ_B_TYPE_BIT = 2;
    localparam int IRQ_A_FLAG_BIT = 1;
    localparam int IRQ_A_TYPE_BIT = 0;

    // ************************************************************
    // Mode register bit positions
    // ************************************************************
    localparam int GATE_B_BIT = 7;
    localparam int SELECT_B_BIT = 6;
    localparam int MODE_B_HI = 5;
    localparam int MODE_B_LO = 4;
    localparam int GATE_A_BIT = 3;
    localparam int SELECT_A_BIT = 2;
    localparam int MODE_A_HI = 1;
    localparam int MODE_A_LO = 0;

    // ************************************************************
    // Pin vector positions and count constants
    // ************************************************************
    localparam int PIN_CNT_A = 0;
    localparam int PIN_CNT_B = 1;
    localparam int PIN_IRQ_A = 2;
    localparam int PIN_IRQ_B = 3;
    localparam int PIN_COUNT = 4;
    localparam logic [4:0] PRESCALE_ALL_ONES = 5'h1f;
    localparam logic [4:0] PRESCALE_ZERO = 5'h00;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
    localparam logic [7:0] BYTE_ONE = 8'h01;

    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } count_mode_e;

endpackage

// >>> dual_timer_counter_pair.sv
// Purpose: Two 16-bit timer/counters with shared control and flag register.
// Assumes: One core clock; pins are asynchronous and are synchronised here.
// Notes: Reads answer one cycle after the read strobe; writes act at once.
//
// Contract
// [R01] Overflow flags set by overflow, cleared when the core vectors.
// [R02] Run bits written by software turn each counter on and off.
// [R03] External flags set by falling edge or low level per type bit.
// [R04] Vectoring clears edge flags only; level flags follow the pin.
// [R05] Trigger type set selects falling edge, clear selects low level.
// [R06] Each counter is two byte registers, joined or separate by mode.
// [R07] Control register and counter bytes reset to zero; bit writable.
// [R08] Mode 0 counts high byte plus low five bits of low byte.
// [R09] Wrap from all ones to zero sets the counter's overflow flag.
// [R10] Count only while run is set and gate clear or irq pin high.
// [R11] Setting run keeps the byte values; counting resumes from them.
// [R12] No prescaler; each step follows the core clock directly.
// [R13] Mode 1 is mode 0 but with all sixteen bits.
// [R14] Mode 2 reloads low byte from high byte on low byte overflow.
// [R15] Counter B in mode 3 holds its count as if stopped.
// [R16] Counter A mode 3 low byte uses counter A controls and flag.
// [R17] Counter A mode 3 high byte times cycles, uses B run and flag.
// [R18] With A in mode 3, B runs outside mode 3; overflow feeds baud.
// [R19] Two-bit mode field selects 13-bit, 16-bit, reload, split.
// [R20] Timer function increments once each core clock.
// [R21] Counter function counts a sampled high then low on the pin.
// [R22] Select bit set counts the pin, clear counts the clock.
// [R23] Software writes to flags act like hardware updates.
`timescale 1ns/100ps
module dual_timer_counter_pair
    import timer_pair_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic sfr_bit_wr,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic sfr_bit_val,
    input wire logic vec_ack_ovf_a,
    input wire logic vec_ack_ovf_b,
    input wire logic vec_ack_irq_a,
    input wire logic vec_ack_irq_b,
    input wire logic ext_irq_a_pin,
    input wire logic ext_irq_b_pin,
    input wire logic counter_a_ext_input,
    input wire logic counter_b_ext_input,
    output logic [7:0] sfr_rdata,
    output logic counter_a_overflow_flag,
    output logic counter_b_overflow_flag,
    output logic ext_irq_a_flag,
    output logic ext_irq_b_flag,
    output logic counter_b_overflow_pulse
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mode_cfg;
        logic [7:0] lo_a;
        logic [7:0] hi_a;
        logic [7:0] lo_b;
        logic [7:0] hi_b;
        logic [PIN_COUNT-1:0] pin_s1;
        logic [PIN_COUNT-1:0] pin_s2;
        logic [PIN_COUNT-1:0] pin_s3;
        logic [7:0] rdata;
        logic baud;
    } state_s;

    state_s s_q;
    state_s s_d;
    count_mode_e mode_a;
    count_mode_e mode_b;
    logic [PIN_COUNT-1:0] fall;
    logic tick_a;
    logic tick_b;
    logic run_a;
    logic run_b;
    logic split_hi_run;
    logic ovf_a;
    logic ovf_b;
    logic ovf_split_hi;
    logic wr_lo_a;
    logic wr_hi_a;
    logic wr_lo_b;
    logic wr_hi_b;
    logic [16:0] step_a;
    logic [16:0] step_b;
    // Interrupt pins idle high; starting their stages high keeps a
    // level-mode flag from rising for a few cycles after reset.
    localparam logic [PIN_COUNT-1:0] PIN_IDLE =
        PIN_COUNT'((1 << PIN_IRQ_A) | (1 << PIN_IRQ_B));

    // One count step for modes 0 to 2; returns {overflow, high, low}.
    // In 13-bit mode the upper three low-byte bits are left untouched.
    function automatic logic [16:0] count_step(
        input count_mode_e mode,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        logic [16:0] r;
        r = {1'b0, hi, lo};
        case (mode)
            MODE_13BIT: begin // see [R08]
                if (lo[4:0] == PRESCALE_ALL_ONES) begin
                    r[4:0] = PRESCALE_ZERO;
                    r[15:8] = hi + BYTE_ONE;
                    r[16] = (hi == BYTE_ALL_ONES); // see [R09]
                end else begin
                    r[4:0] = lo[4:0] + PRESCALE_ZERO + 5'h01;
                end
            end
            MODE_16BIT: begin // see [R13]
                r[15:0] = {hi, lo} + 16'h0001;
                r[16] = ({hi, lo} == {BYTE_ALL_ONES, BYTE_ALL_ONES});
            end
            MODE_RELOAD: begin // see [R14]
                if (lo == BYTE_ALL_ONES) begin
                    r[7:0] = hi;
                    r[16] = 1'b1;
                end else begin
                    r[7:0] = lo + BYTE_ONE;
                end
            end
            default: begin
                r = {1'b0, hi, lo};
            end
        endcase
        return r;
    endfunction

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.pin_s1 = {ext_irq_b_pin, ext_irq_a_pin,
                      counter_b_ext_input, counter_a_ext_input};
        s_d.pin_s2 = s_q.pin_s1;
        s_d.pin_s3 = s_q.pin_s2;
        // Edges are judged on the second and third stages only.
        fall = s_q.pin_s3 & ~s_q.pin_s2; // see [R21]
        mode_a = count_mode_e'(s_q.mode_cfg[MODE_A_HI:MODE_A_LO]); // see [R19]
        mode_b = count_mode_e'(s_q.mode_cfg[MODE_B_HI:MODE_B_LO]);
        // No prescaler: a timer tick is every clock.
        tick_a = s_q.mode_cfg[SELECT_A_BIT] ? fall[PIN_CNT_A] : 1'b1; // see [R12], [R20], [R22]
        tick_b = s_q.mode_cfg[SELECT_B_BIT] ? fall[PIN_CNT_B] : 1'b1; // see [R22]
        run_a = s_q.ctrl[RUN_A_BIT] && (!s_q.mode_cfg[GATE_A_BIT]
                || s_q.pin_s2[PIN_IRQ_A]); // see [R02], [R10], [R16]
        // With A split, B's run bit belongs to A's high byte, so B is
        // switched only by leaving or entering its own mode 3 and by its gate with the irq B pin.
        if (mode_a == MODE_SPLIT) begin
            run_b = (mode_b != MODE_SPLIT) && (!s_q.mode_cfg[GATE_B_BIT]
                    || s_q.pin_s2[PIN_IRQ_B]); // see [R18]
        end else begin
            run_b = s_q.ctrl[RUN_B_BIT] && (mode_b != MODE_SPLIT)
                    && (!s_q.mode_cfg[GATE_B_BIT]
                    || s_q.pin_s2[PIN_IRQ_B]); // see [R02], [R10], [R15]
        end
        split_hi_run = (mode_a == MODE_SPLIT) && s_q.ctrl[RUN_B_BIT]; // see [R17]

        ovf_a = 1'b0;
        ovf_b = 1'b0;
        ovf_split_hi = 1'b0;
        step_a = count_step(mode_a, s_q.lo_a, s_q.hi_a);
        step_b = count_step(mode_b, s_q.lo_b, s_q.hi_b);

        // Counter A; bytes carry their values across run changes.
        if (run_a && tick_a) begin // see [R11]
            if (mode_a == MODE_SPLIT) begin
                s_d.lo_a = s_q.lo_a + BYTE_ONE; // see [R16]
                ovf_a = (s_q.lo_a == BYTE_ALL_ONES);
            end else begin
                {ovf_a, s_d.hi_a, s_d.lo_a} = step_a; // see [R06]
            end
        end
        if (split_hi_run) begin
            s_d.hi_a = s_q.hi_a + BYTE_ONE; // see [R17]
            ovf_split_hi = (s_q.hi_a == BYTE_ALL_ONES);
        end

        // Counter B.
        if (run_b && tick_b) begin
            {ovf_b, s_d.hi_b, s_d.lo_b} = step_b; // see [R06], [R09]
        end
        s_d.baud = ovf_b; // see [R18]

        // Software writes to the byte registers win over counting.
        wr_lo_a = sfr_wr && (sfr_addr == ADDR_COUNTER_A_LOW_BYTE);
        wr_hi_a = sfr_wr && (sfr_addr == ADDR_COUNTER_A_HIGH_BYTE);
        wr_lo_b = sfr_wr && (sfr_addr == ADDR_COUNTER_B_LOW_BYTE);
        wr_hi_b = sfr_wr && (sfr_addr == ADDR_COUNTER_B_HIGH_BYTE);
        if (wr_lo_a) begin
            s_d.lo_a = sfr_wdata;
        end
        if (wr_hi_a) begin
            s_d.hi_a = sfr_wdata;
        end
        if (wr_lo_b) begin
            s_d.lo_b = sfr_wdata;
        end
        if (wr_hi_b) begin
            s_d.hi_b = sfr_wdata;
        end
        if (sfr_wr && (sfr_addr == ADDR_TIMER_MODE_CONFIG)) begin
            s_d.mode_cfg = sfr_wdata;
        end

        // Control register: vector clears, then software, then hardware
        // sets, so an event in the clearing cycle is never lost.
        if (vec_ack_ovf_a) begin
            s_d.ctrl[OVF_A_BIT] = 1'b0; // see [R01]
        end
        if (vec_ack_ovf_b) begin
            s_d.ctrl[OVF_B_BIT] = 1'b0; // see [R01]
        end
        if (vec_ack_irq_a && s_q.ctrl[IRQ_A_TYPE_BIT]) begin
            s_d.ctrl[IRQ_A_FLAG_BIT] = 1'b0; // see [R04]
        end
        if (vec_ack_irq_b && s_q.ctrl[IRQ_B_TYPE_BIT]) begin
            s_d.ctrl[IRQ_B_FLAG_BIT] = 1'b0; // see [R04]
        end
        if (sfr_wr && (sfr_addr == ADDR_TIMER_CONTROL_FLAGS)) begin
            s_d.ctrl = sfr_wdata; // see [R02], [R23]
        end
        if (sfr_bit_wr) begin
            s_d.ctrl[sfr_bit_sel] = sfr_bit_val; // see [R07], [R23]
        end
        if (ovf_a) begin
            s_d.ctrl[OVF_A_BIT] = 1'b1; // see [R01], [R09]
        end
        if (ovf_split_hi || (ovf_b && (mode_a != MODE_SPLIT))) begin
            s_d.ctrl[OVF_B_BIT] = 1'b1; // see [R01], [R17]
        end
        // Type bit set: falling edge; clear: flag mirrors the low level.
        if (s_q.ctrl[IRQ_A_TYPE_BIT]) begin
            if (fall[PIN_IRQ_A]) begin
                s_d.ctrl[IRQ_A_FLAG_BIT] = 1'b1; // see [R03], [R05]
            end
        end else begin
            s_d.ctrl[IRQ_A_FLAG_BIT] = !s_q.pin_s2[PIN_IRQ_A]; // see [R04], [R05]
        end
        if (s_q.ctrl[IRQ_B_TYPE_BIT]) begin
            if (fall[PIN_IRQ_B]) begin
                s_d.ctrl[IRQ_B_FLAG_BIT] = 1'b1; // see [R03], [R05]
            end
        end else begin
            s_d.ctrl[IRQ_B_FLAG_BIT] = !s_q.pin_s2[PIN_IRQ_B]; // see [R04]
        end

        // Reads return the value held before this cycle's updates.
        if (sfr_rd) begin
            case (sfr_addr)
                ADDR_TIMER_CONTROL_FLAGS: s_d.rdata = s_q.ctrl;
                ADDR_TIMER_MODE_CONFIG: s_d.rdata = s_q.mode_cfg;
                ADDR_COUNTER_A_LOW_BYTE: s_d.rdata = s_q.lo_a;
                ADDR_COUNTER_B_LOW_BYTE: s_d.rdata = s_q.lo_b;
                ADDR_COUNTER_A_HIGH_BYTE: s_d.rdata = s_q.hi_a;
                ADDR_COUNTER_B_HIGH_BYTE: s_d.rdata = s_q.hi_b;
                default: s_d.rdata = REG_RESET;
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0; // see [R07]
            s_q.pin_s1 <= PIN_IDLE;
            s_q.pin_s2 <= PIN_IDLE;
            s_q.pin_s3 <= PIN_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign sfr_rdata = s_q.rdata;
    assign counter_a_overflow_flag = s_q.ctrl[OVF_A_BIT];
    assign counter_b_overflow_flag = s_q.ctrl[OVF_B_BIT];
    assign ext_irq_a_flag = s_q.ctrl[IRQ_A_FLAG_BIT];
    assign ext_irq_b_flag = s_q.ctrl[IRQ_B_FLAG_BIT];
    assign counter_b_overflow_pulse = s_q.baud;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_ovf_a_sets;
        @(posedge sys_clk) disable iff (!rstn)
        ovf_a |=> s_q.ctrl[OVF_A_BIT];
    endproperty
    a_ovf_a_sets: assert property (p_ovf_a_sets) // see [R01]
        else $error("Counter A overflow did not set its flag.");

    property p_stopped_holds;
        @(posedge sys_clk) disable iff (!rstn)
        (!s_q.ctrl[RUN_A_BIT] && !wr_lo_a) |=> $stable(s_q.lo_a);
    endproperty
    a_stopped_holds: assert property (p_stopped_holds) // see [R02]
        else $error("Counter A low byte moved while stopped.");

    property p_edge_flag;
        @(posedge sys_clk) disable iff (!rstn)
        (s_q.ctrl[IRQ_A_TYPE_BIT] && fall[PIN_IRQ_A]) |=>
            s_q.ctrl[IRQ_A_FLAG_BIT];
    endproperty
    a_edge_flag: assert property (p_edge_flag) // see [R03]
        else $error("Falling edge on irq A pin lost.");

    property p_level_follows;
        @(posedge sys_clk) disable iff (!rstn)
        !s_q.ctrl[IRQ_B_TYPE_BIT] |=>
            (s_q.ctrl[IRQ_B_FLAG_BIT] == !$past(s_q.pin_s2[PIN_IRQ_B]));
    endproperty
    a_level_follows: assert property (p_level_follows) // see [R04]
        else $error("Level irq B flag does not follow its pin.");

    property p_gate_blocks;
        @(posedge sys_clk) disable iff (!rstn)
        (s_q.mode_cfg[GATE_A_BIT] && !s_q.pin_s2[PIN_IRQ_A] && !wr_lo_a)
            |=> $stable(s_q.lo_a);
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) // see [R10]
        else $error("Gated counter A counted with irq pin low.");

    property p_reload;
        @(posedge sys_clk) disable iff (!rstn)
        (mode_a == MODE_RELOAD && ovf_a && !wr_lo_a && !wr_hi_a) |=>
            (s_q.lo_a == s_q.hi_a) && $stable(s_q.hi_a);
    endproperty
    a_reload: assert property (p_reload) // see [R14]
        else $error("Reload did not copy high byte into low byte.");

    property p_b_split_holds;
        @(posedge sys_clk) disable iff (!rstn)
        (mode_b == MODE_SPLIT && !wr_lo_b && !wr_hi_b) |=>
            $stable({s_q.hi_b, s_q.lo_b});
    endproperty
    a_b_split_holds: assert property (p_b_split_holds) // see [R15]
        else $error("Counter B moved in mode 3.");

    property p_split_high;
        @(posedge sys_clk) disable iff (!rstn)
        (split_hi_run && !wr_hi_a) |=>
            (s_q.hi_a == $past(s_q.hi_a) + BYTE_ONE);
    endproperty
    a_split_high: assert property (p_split_high) // see [R17]
        else $error("Split high byte did not count the cycle.");

    property p_timer_step;
        @(posedge sys_clk) disable iff (!rstn)
        (run_a && !s_q.mode_cfg[SELECT_A_BIT] && mode_a == MODE_16BIT
            && s_q.lo_a != BYTE_ALL_ONES && !wr_lo_a) |=>
            (s_q.lo_a == $past(s_q.lo_a) + BYTE_ONE);
    endproperty
    a_timer_step: assert property (p_timer_step) // see [R20]
        else $error("Timer A did not step once per clock.");

endmodule

// >>> core_model.sv
// Purpose: Core stand-in driving the special function register bus.
// Assumes: Strobes launch after a rising edge and are taken at the next.
// Notes: Idle write data is inverted so a stale value can never pass.
`timescale 1ns/100ps
module core_model (
    input wire logic sys_clk,
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic [7:0] sfr_wdata,
    output logic sfr_rd,
    output logic sfr_bit_wr,
    output logic [2:0] sfr_bit_sel,
    output logic sfr_bit_val,
    output logic [3:0] vec_ack,
    input wire logic [7:0] sfr_rdata
);
    initial begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        sfr_rd = 1'b0;
        sfr_bit_wr = 1'b0;
        sfr_bit_sel = 3'h0;
        sfr_bit_val = 1'b0;
        vec_ack = 4'h0;
    end

    // ************************************************************
    // Bus cycles
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
        sfr_wdata <= ~d;
    endtask

    // Read data is registered, so it is taken just after the strobe edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
        #1;
        d = sfr_rdata;
    endtask

    task automatic bw(input logic [2:0] b, input logic v);
        @(posedge sys_clk);
        sfr_bit_sel <= b;
        sfr_bit_val <= v;
        sfr_bit_wr <= 1'b1;
        @(posedge sys_clk);
        sfr_bit_wr <= 1'b0;
        sfr_bit_val <= ~v;
    endtask

    // The core vectors once per routine entry, hence a single pulse.
    task automatic ack(input int i);
        @(posedge sys_clk);
        vec_ack[i] <= 1'b1;
        @(posedge sys_clk);
        vec_ack[i] <= 1'b0;
    endtask
endmodule

// >>> testbench.sv
// Purpose: Self-checking bench for the dual timer/counter pair.
// Assumes: The core stand-in issues one-cycle strobes after rising edges.
// Notes: Counts are predicted by an integer model of the four modes.
`timescale 1ns/100ps
`define CHECK(nm, e, g) begin \
    comparisons++; \
    if ((g) !== 8'(e)) begin \
        fails++; \
        $display("ERROR %s expected %h seen %h", nm, 8'(e), g); \
    end \
end
module testbench
    import timer_pair_pkg::*;
;
    typedef struct {int sel; int cfg; int md; int hi; int lo; int n;
        int pin;} row_s;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] irq_pin = 2'b11;
    logic [1:0] cnt_pin = 2'b00;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_v;
    logic sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, b_pulse;
    logic [2:0] sfr_bit_sel;
    logic [3:0] vec_ack;
    logic [1:0] ovf, irq_flag;
    int fails = 0;
    int comparisons = 0;
    int pulses = 0;
    int seed = 32'h0931;
    int k;
    row_s rows[9] = '{'{0, 8'h00, 0, 8'hff, 8'hfe, 3, 1},
        '{0, 8'h01, 1, 8'hff, 8'hfe, 3, 1},
        '{0, 8'h02, 2, 8'h80, 8'hfd, 3, 1},
        '{0, 8'h09, 4, 8'h12, 8'h34, 3, 0},
        '{0, 8'h09, 1, 8'h00, 8'hfb, 3, 1},
        '{1, 8'h20, 2, 8'hf0, 8'hfe, 3, 1},
        '{1, 8'h30, 4, 8'h12, 8'h34, 3, 1},
        '{0, 8'h03, 3, 8'h55, 8'hfe, 3, 1},
        '{2, 8'h03, 3, 8'h34, 8'hfd, 3, 1}};

    dual_timer_counter_pair DUT (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd),
        .sfr_bit_wr(sfr_bit_wr),
        .sfr_bit_sel(sfr_bit_sel),
        .sfr_bit_val(sfr_bit_val),
        .vec_ack_ovf_a(vec_ack[0]),
        .vec_ack_ovf_b(vec_ack[1]),
        .vec_ack_irq_a(vec_ack[2]),
        .vec_ack_irq_b(vec_ack[3]),
        .ext_irq_a_pin(irq_pin[0]),
        .ext_irq_b_pin(irq_pin[1]),
        .counter_a_ext_input(cnt_pin[0]),
        .counter_b_ext_input(cnt_pin[1]),
        .sfr_rdata(sfr_rdata),
        .counter_a_overflow_flag(ovf[0]),
        .counter_b_overflow_flag(ovf[1]),
        .ext_irq_a_flag(irq_flag[0]),
        .ext_irq_b_flag(irq_flag[1]),
        .counter_b_overflow_pulse(b_pulse)
    );

    core_model core (
        .sys_clk(sys_clk),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd),
        .sfr_bit_wr(sfr_bit_wr),
        .sfr_bit_sel(sfr_bit_sel),
        .sfr_bit_val(sfr_bit_val),
        .vec_ack(vec_ack),
        .sfr_rdata(sfr_rdata)
    );

    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (b_pulse === 1'b1) pulses++;

    // ************************************************************
    // Model and helpers
    // ************************************************************
    function automatic void model(input int md, input int n, inout int hi,
        inout int lo, inout int w);
        int v;
        for (int i = 0; i < n; i++) begin
            case (md)
                0: begin
                    v = (hi * 32 + lo % 32 + 1) % 8192;
                    w += (v == 0);
                    hi = v / 32;
                    lo = (lo / 32) * 32 + v % 32;
                end
                1: begin
                    v = (hi * 256 + lo + 1) % 65536;
                    w += (v == 0);
                    hi = v / 256;
                    lo = v % 256;
                end
                2: begin
                    lo = lo + 1;
                    if (lo == 256) begin
                        lo = hi;
                        w++;
                    end
                end
                3: begin
                    lo = (lo + 1) % 256;
                    w += (lo == 0);
                end
                default: ;
            endcase
        end
    endfunction

    task automatic wait_n(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e,
        input string nm);
        core.rd(a, rd_v);
        `CHECK(nm, e, rd_v)
    endtask

    // Run time is fixed by the bus cycles: n waits plus two strobe edges.
    task automatic run_row(input row_s r);
        logic [7:0] la, ha;
        int rb, ob, hi, lo, w;
        la = r.sel == 0 ? 8'h8a : r.sel == 1 ? 8'h8b : 8'h8c;
        ha = r.sel == 0 ? 8'h8c : r.sel == 1 ? 8'h8d : 8'h8a;
        rb = r.sel == 0 ? 4 : 6;
        ob = rb + 1;
        hi = r.hi;
        lo = r.lo;
        w = 0;
        irq_pin[0] <= r.pin[0];
        core.wr(ADDR_TIMER_MODE_CONFIG, 8'(r.cfg));
        core.wr(la, 8'(lo));
        core.wr(ha, 8'(hi));
        core.bw(3'(ob), 1'b0);
        pulses = 0;
        core.bw(3'(rb), 1'b1);
        wait_n(r.n);
        core.bw(3'(rb), 1'b0);
        model(r.md, r.n + 2, hi, lo, w);
        chk_rd(la, 8'(lo), "low byte");
        chk_rd(ha, 8'(hi), "high byte");
        chk_rd(8'h88, 8'((w > 0 ? 1 << ob : 0) | (r.pin == 0 ? 2 : 0)),
            "control");
        if (r.sel == 1)
            `CHECK("pulses", w, pulses)
        if (w > 0) begin
            core.ack(ob == 7 ? 1 : 0);
            #1;
            `CHECK("overflow", 0, ovf[ob == 7])
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        wait_n(5);
        rstn <= 1'b1;
        for (int a = 8'h88; a <= 8'h8e; a++)
            chk_rd(8'(a), 8'h00, "reset value");
        for (int a = 8'h89; a <= 8'h8d; a++) begin
            k = $random(seed) & (a == 8'h89 ? 8'hfc : 8'hff);
            core.wr(8'(a), 8'(k));
            chk_rd(8'(a), 8'(k), "byte");
        end
        foreach (rows[i])
            run_row(rows[i]);
        // Counter A is split and B sits in mode 0 with its run bit clear,
        // so B must still count: one count edge lies before the read.
        core.wr(ADDR_COUNTER_B_LOW_BYTE, 8'h00);
        chk_rd(ADDR_COUNTER_B_LOW_BYTE, 8'h01, "split b runs");
        for (int i = 0; i < 2; i++) begin
            irq_pin[i] <= 1'b0;
            wait_n(5);
            `CHECK("level flag", 1, irq_flag[i])
            core.ack(2 + i);
            #1;
            `CHECK("level kept", 1, irq_flag[i])
            irq_pin[i] <= 1'b1;
            wait_n(5);
            `CHECK("level follows", 0, irq_flag[i])
            core.bw(3'(2 * i), 1'b1);
            irq_pin[i] <= 1'b0;
            wait_n(5);
            irq_pin[i] <= 1'b1;
            wait_n(5);
            `CHECK("edge flag", 1, irq_flag[i])
            core.ack(2 + i);
            #1;
            `CHECK("edge cleared", 0, irq_flag[i])
            core.bw(3'(2 * i + 1), 1'b1);
            #1;
            `CHECK("software flag", 1, irq_flag[i])
            core.bw(3'(2 * i), 1'b0);
        end
        core.wr(ADDR_TIMER_MODE_CONFIG, 8'h55);
        for (int a = 8'h8a; a <= 8'h8d; a++)
            core.wr(8'(a), 8'h00);
        core.bw(3'd4, 1'b1);
        core.bw(3'd6, 1'b1);
        k = 3 + $unsigned($random(seed)) % 4;
        // Each level is held two cycles, above the one-cycle minimum.
        repeat (k) begin
            cnt_pin <= 2'b11;
            wait_n(2);
            cnt_pin <= 2'b00;
            wait_n(2);
        end
        wait_n(6);
        core.bw(3'd4, 1'b0);
        core.bw(3'd6, 1'b0);
        chk_rd(8'h8a, 8'(k), "pin count a");
        chk_rd(8'h8b, 8'(k), "pin count b");
        close_out();
    end

    initial begin
        #(40 * 20000);
        fails++;
        close_out();
    end
endmodule
